// *** design/crf_map.svh ***
// Constants for the CPU working register file and condition flags.
// Assumes inclusion by bare name from the package and the design module.
`ifndef CRF_MAP_SVH
`define CRF_MAP_SVH

// Working register file geometry
`define CRF_NUM_REGS     32
`define CRF_PTR_X_LOW    5'h1A
`define CRF_PTR_X_HIGH   5'h1B
`define CRF_PTR_Y_LOW    5'h1C
`define CRF_PTR_Y_HIGH   5'h1D
`define CRF_PTR_Z_LOW    5'h1E
`define CRF_PTR_Z_HIGH   5'h1F
`define CRF_REG_RESET    8'h00

// Data space map
`define CRF_REG_LAST     16'h001F
`define CRF_IO_BASE      16'h0020
`define CRF_IO_LAST      16'h005F
`define CRF_EXT_LAST     16'h00FF

// Condition flag bit positions
`define CRF_FLAG_I       3'd7
`define CRF_FLAG_T       3'd6
`define CRF_FLAG_H       3'd5
`define CRF_FLAG_S       3'd4
`define CRF_FLAG_V       3'd3
`define CRF_FLAG_N       3'd2
`define CRF_FLAG_Z       3'd1
`define CRF_FLAG_C       3'd0
`define CRF_FLAGS_RESET  8'h00

// Stack, program counter and interrupt figures
`define CRF_SP_STEP      16'h0002
`define CRF_SP_RESET     16'h0000
`define CRF_PC_RESET     16'h0000
`define CRF_PC_STEP      16'h0001
`define CRF_NUM_IRQ      8
`define CRF_VEC_BASE     16'h0001
`define CRF_VEC_STRIDE   16'h0001

`endif

// *** design/crf_pkg.sv ***
// Types shared by the working register file and its verification.
// Assumes crf_map.svh sits on the include path.
`include "crf_map.svh"

package crf_pkg;

  // Data space region of an address, one-hot
  typedef enum logic [3:0] {
    CRF_RGN_REG  = 4'b0001,
    CRF_RGN_IO   = 4'b0010,
    CRF_RGN_EXT  = 4'b0100,
    CRF_RGN_MEM  = 4'b1000
  } crf_region_e;

  typedef logic [4:0] crf_idx_t;
  typedef logic [7:0] crf_byte_t;

  // Operand read and result write request from the decoder
  typedef struct packed {
    crf_idx_t    rd_a_idx;   // First 8-bit operand
    crf_idx_t    rd_b_idx;   // Second 8-bit operand
    crf_idx_t    pair_idx;   // 16-bit operand, low byte index
    logic        wr_en;
    logic        wr_wide;    // Result is 16 bits into a pair
    crf_idx_t    wr_idx;
    logic [15:0] wr_data;
  } crf_rf_req_s;

  // Flag outcome of one ALU operation with per-flag update enables
  typedef struct packed {
    logic       upd;         // Any ALU operation finished
    logic [4:0] mask;        // H V N Z C update enables
    logic       h;
    logic       v;
    logic       n;
    logic       z;
    logic       c;
  } crf_alu_flags_s;

  // Control operations issued by the decoder
  typedef struct packed {
    logic       instr_done;  // An instruction completes this cycle
    logic       long_instr;  // Executing word has a second word
    logic       jump_en;
    logic [15:0] jump_target;
    logic       call_op;
    logic       ret_op;
    logic       irq_return_op;
    logic       int_set_op;
    logic       int_clr_op;
    logic       bit_store_op;
    logic       bit_load_op;
    crf_idx_t   bit_reg;
    logic [2:0] bit_pos;
  } crf_ctrl_s;

  // Whole state of the block
  typedef struct packed {
    logic [`CRF_NUM_REGS-1:0][7:0] regs;
    crf_byte_t   flags;
    logic [15:0] stack_pointer;
    logic [15:0] program_counter;
    logic [15:0] exec_word;
    logic [15:0] second_word;
    logic        second_due;
    logic        holdoff;
    logic        irq_take;
    logic [2:0]  irq_vec;
    logic        push_req;
    logic [15:0] push_data;
  } crf_state_s;

endpackage : crf_pkg

// *** design/crf_core.sv ***
// Working register file, condition flags, stack pointer, fetch stage and
// interrupt gate of the 8-bit CPU core.
// Assumes a decoder drives the request structs, the ALU computes results
// combinationally from the operand outputs, and memories sit outside.
`timescale 1ns/1ns
`default_nettype none
`include "crf_map.svh"

module crf_core
  import crf_pkg::*;
(
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire crf_rf_req_s            rf_req,
  input  wire crf_alu_flags_s         alu_flags,
  input  wire crf_ctrl_s              ctrl,
  input  wire logic                   flags_wr_en,
  input  wire logic [7:0]             flags_wr_data,
  input  wire logic                   sp_wr_en,
  input  wire logic [15:0]            sp_wr_data,
  input  wire logic [15:0]            fetch_word,
  input  wire logic [`CRF_NUM_IRQ-1:0] irq_req,
  input  wire logic [15:0]            ds_addr,
  input  wire logic                   ds_re,
  input  wire logic                   ds_we,
  input  wire logic [7:0]             ds_wdata,
  input  wire logic                   io_direct,
  input  wire logic [5:0]             io_addr,
  output logic [7:0]                  rd_a,
  output logic [7:0]                  rd_b,
  output logic [15:0]                 rd_pair,
  output logic [15:0]                 ptr_x,
  output logic [15:0]                 ptr_y,
  output logic [15:0]                 ptr_z,
  output logic [15:0]                 table_addr,
  output logic [7:0]                  condition_flags,
  output logic [15:0]                 stack_pointer,
  output logic [15:0]                 fetch_addr,
  output logic [15:0]                 exec_word,
  output logic [15:0]                 second_word,
  output logic                        second_due,
  output logic                        irq_take,
  output logic [2:0]                  irq_vec,
  output logic                        push_req,
  output logic [15:0]                 push_addr,
  output logic [15:0]                 push_data,
  output crf_region_e                 ds_region,
  output logic [7:0]                  ds_rdata,
  output logic                        per_sel,
  output logic [7:0]                  per_addr
);

  crf_state_s st;
  crf_state_s next_st;

  // Data space decode, used for load/store addresses and pointer hits
  function automatic crf_region_e region_of(input logic [15:0] a);
    if (a <= `CRF_REG_LAST) begin
      return CRF_RGN_REG;
    end else if (a <= `CRF_IO_LAST) begin
      return CRF_RGN_IO;
    end else if (a <= `CRF_EXT_LAST) begin
      return CRF_RGN_EXT;
    end else begin
      return CRF_RGN_MEM;
    end
  endfunction : region_of

  // Pair read, low byte at the even index
  function automatic logic [15:0] pair_of(
    input logic [`CRF_NUM_REGS-1:0][7:0] r,
    input crf_idx_t                      lo
  );
    crf_idx_t base;
    base = {lo[4:1], 1'b0};
    return {r[base + 5'd1], r[base]};
  endfunction : pair_of

  // Operand ports read the flops directly so the ALU sees them this cycle
  assign rd_a    = st.regs[rf_req.rd_a_idx];
  assign rd_b    = st.regs[rf_req.rd_b_idx];
  assign rd_pair = pair_of(st.regs, rf_req.pair_idx);

  // Pointer views of the top six registers
  assign ptr_x      = {st.regs[`CRF_PTR_X_HIGH], st.regs[`CRF_PTR_X_LOW]};
  assign ptr_y      = {st.regs[`CRF_PTR_Y_HIGH], st.regs[`CRF_PTR_Y_LOW]};
  assign ptr_z      = {st.regs[`CRF_PTR_Z_HIGH], st.regs[`CRF_PTR_Z_LOW]};
  assign table_addr = ptr_z;

  // Peripheral select: direct I/O is only six bits wide, so it can never
  // reach the extended region; that region needs a data-space access
  assign ds_region = region_of(ds_addr);
  always_comb begin
    per_sel  = 1'b0;
    per_addr = 8'h00;
    if (io_direct) begin
      per_sel  = 1'b1;
      per_addr = 8'(`CRF_IO_BASE) + {2'b00, io_addr};
    end else if ((ds_re || ds_we) &&
                 (ds_region == CRF_RGN_IO || ds_region == CRF_RGN_EXT)) begin
      per_sel  = 1'b1;
      per_addr = ds_addr[7:0];
    end
  end

  // Register hit on a data-space read returns the register, not memory
  assign ds_rdata = (ds_region == CRF_RGN_REG) ?
                    st.regs[ds_addr[4:0]] : 8'h00;

  assign condition_flags = st.flags;
  assign stack_pointer   = st.stack_pointer;
  assign fetch_addr      = st.program_counter;
  assign exec_word       = st.exec_word;
  assign second_word     = st.second_word;
  assign second_due      = st.second_due;
  assign irq_take        = st.irq_take;
  assign irq_vec         = st.irq_vec;
  assign push_req        = st.push_req;
  assign push_addr       = st.stack_pointer;
  assign push_data       = st.push_data;

  // Next-state logic for the whole block
  always_comb begin
    logic        irq_any;
    logic [2:0]  irq_win;
    logic        s_new;
    logic [7:0]  bit_val;
    logic [15:0] ret_pc;
    irq_any = 1'b0;
    irq_win = 3'd0;
    s_new   = 1'b0;
    bit_val = 8'h00;
    ret_pc  = st.program_counter;
    next_st = st;
    next_st.irq_take = 1'b0;
    next_st.push_req = 1'b0;

    // Result write-back; the pair form writes both bytes at once
    if (rf_req.wr_en) begin
      if (rf_req.wr_wide) begin
        next_st.regs[{rf_req.wr_idx[4:1], 1'b0}] =
          rf_req.wr_data[7:0];
        next_st.regs[{rf_req.wr_idx[4:1], 1'b1}] =
          rf_req.wr_data[15:8];
      end else begin
        next_st.regs[rf_req.wr_idx] = rf_req.wr_data[7:0];
      end
    end

    // Store through a pointer into the register region hits the file
    if (ds_we && region_of(ds_addr) == CRF_RGN_REG) begin
      next_st.regs[ds_addr[4:0]] = ds_wdata;
    end

    // Bit copy between a register bit and the copy store
    bit_val = st.regs[ctrl.bit_reg];
    if (ctrl.bit_store_op) begin
      next_st.flags[`CRF_FLAG_T] = bit_val[ctrl.bit_pos];
    end
    if (ctrl.bit_load_op) begin
      bit_val[ctrl.bit_pos]       = st.flags[`CRF_FLAG_T];
      next_st.regs[ctrl.bit_reg]  = bit_val;
    end

    // Arithmetic flags; sign is rebuilt whenever N or V move
    if (alu_flags.upd) begin
      if (alu_flags.mask[4]) begin
        next_st.flags[`CRF_FLAG_H] = alu_flags.h;
      end
      if (alu_flags.mask[3]) begin
        next_st.flags[`CRF_FLAG_V] = alu_flags.v;
      end
      if (alu_flags.mask[2]) begin
        next_st.flags[`CRF_FLAG_N] = alu_flags.n;
      end
      if (alu_flags.mask[1]) begin
        next_st.flags[`CRF_FLAG_Z] = alu_flags.z;
      end
      if (alu_flags.mask[0]) begin
        next_st.flags[`CRF_FLAG_C] = alu_flags.c;
      end
    end

    // Software write of the whole flag byte, then hardware I-bit changes
    if (flags_wr_en) begin
      next_st.flags = flags_wr_data;
    end
    if (ctrl.int_clr_op) begin
      next_st.flags[`CRF_FLAG_I] = 1'b0;
    end
    if (ctrl.int_set_op || ctrl.irq_return_op) begin
      next_st.flags[`CRF_FLAG_I] = 1'b1;
    end
    s_new = next_st.flags[`CRF_FLAG_N] ^ next_st.flags[`CRF_FLAG_V];
    next_st.flags[`CRF_FLAG_S] = s_new;

    // Stack pointer: software load, then hardware steps
    if (sp_wr_en) begin
      next_st.stack_pointer = sp_wr_data;
    end
    if (ctrl.call_op) begin
      next_st.stack_pointer = st.stack_pointer - `CRF_SP_STEP;
      next_st.push_req      = 1'b1;
      next_st.push_data     = st.program_counter;
    end else if (ctrl.ret_op || ctrl.irq_return_op) begin
      next_st.stack_pointer = st.stack_pointer + `CRF_SP_STEP;
    end

    // Fetch stage: the next word is taken while this one executes
    if (ctrl.instr_done) begin
      next_st.exec_word       = fetch_word;
      next_st.program_counter = st.program_counter + `CRF_PC_STEP;
      next_st.second_due      = 1'b0;
      if (ctrl.long_instr && !st.second_due) begin
        next_st.second_word = fetch_word;
        next_st.second_due  = 1'b1;
      end
      if (ctrl.jump_en) begin
        next_st.program_counter = ctrl.jump_target;
      end
    end

    // Priority: scan from the top so the lowest pending index is kept
    for (int i = `CRF_NUM_IRQ - 1; i >= 0; i--) begin
      if (irq_req[i]) begin
        irq_any = 1'b1;
        irq_win = 3'(i);
      end
    end

    // Hold-off lasts until one instruction of the main flow has run
    if (ctrl.irq_return_op || ctrl.int_set_op) begin
      next_st.holdoff = 1'b1;
    end else if (ctrl.instr_done) begin
      next_st.holdoff = 1'b0;
    end

    // Interrupts are taken only at an instruction boundary; the flag byte
    // is left as it is apart from the I-bit
    if (ctrl.instr_done && irq_any && st.flags[`CRF_FLAG_I] &&
        !st.holdoff && !ctrl.int_clr_op && !ctrl.call_op &&
        !ctrl.irq_return_op && !ctrl.ret_op && !flags_wr_en) begin
      ret_pc                     = ctrl.jump_en ? ctrl.jump_target :
                                   st.program_counter;
      next_st.irq_take           = 1'b1;
      next_st.irq_vec            = irq_win;
      next_st.flags[`CRF_FLAG_I] = 1'b0;
      next_st.stack_pointer      = st.stack_pointer - `CRF_SP_STEP;
      next_st.push_req           = 1'b1;
      next_st.push_data          = ret_pc;
      next_st.program_counter    = `CRF_VEC_BASE +
                                   16'(irq_win) * `CRF_VEC_STRIDE;
      next_st.second_due         = 1'b0;
    end
  end

  // State register; file and flags clear under reset
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st                 <= '0;
      st.regs            <= '{default: `CRF_REG_RESET};
      st.flags           <= `CRF_FLAGS_RESET;
      st.stack_pointer   <= `CRF_SP_RESET;
      st.program_counter <= `CRF_PC_RESET;
    end else begin
      st <= next_st;
    end
  end

endmodule : crf_core
`default_nettype wire

// *** test/crf_core_sva.sv ***
// Checker for the register file core, bound to every crf_core.
// Assumes the port types of crf_pkg; sees only the core's ports.
`timescale 1ns/1ns
`default_nettype none
module crf_core_sva
  import crf_pkg::*;
(
  input wire logic        clk_sys,
  input wire logic        rst,
  input wire crf_rf_req_s rf_req,
  input wire crf_ctrl_s   ctrl,
  input wire logic        ds_we,
  input wire logic        flags_wr_en,
  input wire logic        io_direct,
  input wire logic [5:0]  io_addr,
  input wire logic [7:0]  rd_a,
  input wire logic [7:0]  condition_flags,
  input wire logic [15:0] stack_pointer,
  input wire logic        irq_take,
  input wire logic        push_req,
  input wire logic [15:0] push_addr,
  input wire logic [7:0]  per_addr
);
  wire logic [7:0] cf = condition_flags;

  // All checks share the core clock and its reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  a_sign_xor: assert property (
    !$past(flags_wr_en) |-> cf[4] == (cf[2] ^ cf[3]))
    else $error("sign flag is not N xor V");
  a_write_seen: assert property (
    rf_req.wr_en && !rf_req.wr_wide && !ds_we && !ctrl.bit_load_op
    |=> rf_req.rd_a_idx != $past(rf_req.wr_idx)
        || rd_a == $past(rf_req.wr_data[7:0]))
    else $error("written byte not seen on operand a");
  a_gate_closed: assert property (
    !cf[7] |=> !irq_take)
    else $error("interrupt taken with global enable clear");
  a_take_clears: assert property (
    irq_take |-> !cf[7] && push_req)
    else $error("take left enable set or pushed nothing");
  // Returning, or enabling while the gate is closed, lets one instruction through first
  a_one_after: assert property (
    (ctrl.irq_return_op || ctrl.int_set_op) && ctrl.instr_done
    |=> !irq_take ##1 !irq_take)
    else $error("interrupt taken without one main instruction");
  a_call_down: assert property (
    ctrl.call_op |=> push_req
      && stack_pointer == $past(stack_pointer) - 16'h0002)
    else $error("call did not push or lower stack by two");
  a_ret_up: assert property (
    ctrl.ret_op || ctrl.irq_return_op
    |=> stack_pointer == $past(stack_pointer) + 16'h0002)
    else $error("return did not raise stack by two");
  // Every push, call or interrupt, lands two below the old stack top
  a_push_top: assert property (
    push_req |-> push_addr == stack_pointer
      && stack_pointer == $past(stack_pointer) - 16'h0002)
    else $error("push address is not the lowered stack top");
  a_io_direct: assert property (
    io_direct |-> per_addr == 8'h20 + {2'b00, io_addr})
    else $error("direct I/O not mapped after the registers");
endmodule : crf_core_sva

bind crf_core crf_core_sva u_sva (
  .clk_sys, .rst, .rf_req, .ctrl, .ds_we, .flags_wr_en, .io_direct,
  .io_addr, .rd_a, .condition_flags, .stack_pointer, .irq_take,
  .push_req, .push_addr, .per_addr
);
`default_nettype wire

// *** test/tb_top.sv ***
// Self-checking bench for the register file core.
// Assumes crf_pkg is compiled first and the checker is bound to the core.
`timescale 1ns/1ns
`default_nettype none
`include "crf_map.svh"
module tb_top
  import crf_pkg::*;
;
  logic                    clk_sys = 1'b0;
  logic                    rst = 1'b1;
  crf_rf_req_s             rf_req = '0;
  crf_alu_flags_s          alu_flags = '0;
  crf_ctrl_s               ctrl = '0;
  logic                    flags_wr_en = 1'b0;
  logic                    sp_wr_en = 1'b0;
  logic                    ds_re = 1'b0;
  logic                    ds_we = 1'b0;
  logic                    io_direct = 1'b0;
  logic [7:0]              flags_wr_data = 8'h00;
  logic [7:0]              ds_wdata = 8'h00;
  logic [5:0]              io_addr = 6'h00;
  logic [15:0]             sp_wr_data = 16'h0000;
  logic [15:0]             fetch_word = 16'h0000;
  logic [15:0]             ds_addr = 16'h0000;
  logic [`CRF_NUM_IRQ-1:0] irq_req = '0;
  logic [7:0]   rd_a, rd_b, condition_flags, ds_rdata, per_addr, fl;
  logic [15:0]  rd_pair, ptr_x, ptr_y, ptr_z, table_addr, stack_pointer;
  logic [15:0]  fetch_addr, exec_word, second_word, push_addr, push_data;
  logic         second_due, irq_take, push_req, per_sel;
  logic [2:0]   irq_vec;
  crf_region_e  ds_region;
  crf_byte_t    mem [32];
  logic [31:0]  r;
  logic [15:0]  q_exp [$];
  int           q_sel [$];
  int           errors = 0;
  int           compares = 0;
  integer       seed = 84662;
  logic [15:0]  ra [6] = '{16'h001F, 16'h0020, 16'h005F, 16'h0060,
                          16'h00FF, 16'h0100};
  logic [3:0]   rg [6] = '{4'h1, 4'h2, 4'h2, 4'h4, 4'h4, 4'h8};

  always #5 clk_sys = ~clk_sys;

  crf_core dut (
    .clk_sys, .rst, .rf_req, .alu_flags, .ctrl, .flags_wr_en,
    .flags_wr_data, .sp_wr_en, .sp_wr_data, .fetch_word, .irq_req,
    .ds_addr, .ds_re, .ds_we, .ds_wdata, .io_direct, .io_addr, .rd_a,
    .rd_b, .rd_pair, .ptr_x, .ptr_y, .ptr_z, .table_addr,
    .condition_flags, .stack_pointer, .fetch_addr, .exec_word,
    .second_word, .second_due, .irq_take, .irq_vec, .push_req,
    .push_addr, .push_data, .ds_region, .ds_rdata, .per_sel, .per_addr
  );

  function automatic logic [15:0] obs(input int s);
    case (s)
      0: return {8'h00, rd_a};
      1: return {8'h00, rd_b};
      2: return rd_pair;
      3: return ptr_x;
      4: return ptr_y;
      5: return ptr_z;
      6: return {8'h00, condition_flags};
      7: return stack_pointer;
      8: return {8'h00, ds_rdata};
      9: return {12'h000, ds_region};
      10: return {15'h0000, irq_take};
      11: return {13'h0000, irq_vec};
      12: return fetch_addr;
      14: return {7'h00, per_sel, per_addr};
      15: return push_data;
      16: return exec_word;
      17: return second_word;
      18: return {15'h0000, second_due};
      19: return table_addr;
      default: return {15'h0000, push_req};
    endcase
  endfunction : obs

  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : step

  task automatic note(input int s, input logic [15:0] e);
    q_sel.push_back(s);
    q_exp.push_back(e);
  endtask : note

  task automatic summarize();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize

  // Mid-cycle compare, so registered outputs have settled
  always @(negedge clk_sys) begin
    while (q_sel.size() > 0) begin
      compares = compares + 1;
      if (obs(q_sel[0]) !== q_exp[0]) begin
        errors = errors + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, obs(q_sel[0]),
                 q_exp[0]);
      end
      void'(q_sel.pop_front());
      void'(q_exp.pop_front());
    end
  end

  // Watchdog, far beyond the hundred or so cycles the run needs
  initial begin
    #20000;
    errors = errors + 1;
    summarize();
  end

  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    fl = 8'h00;
    note(6, 16'h0000);
    rf_req.wr_en = 1'b1;
    for (int i = 0; i < 32; i++) begin
      r = $random(seed);
      mem[i] = r[7:0];
      rf_req.wr_idx = i[4:0];
      rf_req.wr_data = {8'hA5, r[7:0]};  // High byte must be ignored
      step(1);
    end
    rf_req.wr_en = 1'b0;
    for (int i = 0; i < 32; i++) begin
      rf_req.rd_a_idx = i[4:0];
      rf_req.rd_b_idx = 5'd31 - i[4:0];
      note(0, {8'h00, mem[i]});
      note(1, {8'h00, mem[31 - i]});
      step(1);
    end
    // Wide write with an odd index still lands on the X pair
    r = $random(seed);
    rf_req.wr_en = 1'b1;
    rf_req.wr_wide = 1'b1;
    rf_req.wr_idx = 5'h1B;
    rf_req.wr_data = r[15:0];
    rf_req.pair_idx = 5'h1A;
    step(1);
    rf_req.wr_en = 1'b0;
    rf_req.wr_wide = 1'b0;
    note(2, r[15:0]);
    note(3, r[15:0]);
    note(4, {mem[29], mem[28]});
    note(5, {mem[31], mem[30]});
    note(19, {mem[31], mem[30]});
    ds_we = 1'b1;
    ds_addr = 16'h0005;
    ds_wdata = r[23:16];
    mem[5] = r[23:16];
    step(1);
    ds_we = 1'b0;
    ds_re = 1'b1;
    rf_req.rd_a_idx = 5'h05;
    note(8, {8'h00, mem[5]});
    note(0, {8'h00, mem[5]});
    step(1);
    for (int i = 0; i < 6; i++) begin
      ds_addr = ra[i];
      note(9, {12'h000, rg[i]});
      step(1);
    end
    ds_re = 1'b0;
    io_direct = 1'b1;
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      io_addr = r[5:0];
      note(14, {7'h00, 1'b1, 8'h20 + {2'b00, r[5:0]}});
      step(1);
    end
    io_direct = 1'b0;
    // Full updates, then masked ones that must leave the flags alone
    alu_flags.upd = 1'b1;
    for (int i = 0; i < 6; i++) begin
      r = $random(seed);
      alu_flags.mask = (i < 4) ? 5'h1F : 5'h00;
      {alu_flags.h, alu_flags.v, alu_flags.n, alu_flags.z,
       alu_flags.c} = r[4:0];
      step(1);
      if (i < 4) fl = {fl[7:6], r[4], r[3] ^ r[2], r[3:0]};
      note(6, {8'h00, fl});
    end
    alu_flags.upd = 1'b0;
    fl = {1'b0, r[6:5], r[3] ^ r[2], r[3:0]};
    flags_wr_en = 1'b1;
    flags_wr_data = fl;
    step(1);
    flags_wr_en = 1'b0;
    ctrl.bit_store_op = 1'b1;
    ctrl.bit_reg = 5'h05;
    ctrl.bit_pos = r[10:8];
    step(1);
    ctrl.bit_store_op = 1'b0;
    fl[6] = mem[5][r[10:8]];
    note(6, {8'h00, fl});
    step(1);
    ctrl.bit_load_op = 1'b1;
    ctrl.bit_reg = 5'h07;
    ctrl.bit_pos = r[13:11];
    rf_req.rd_a_idx = 5'h07;
    step(1);
    ctrl.bit_load_op = 1'b0;
    mem[7][r[13:11]] = fl[6];
    note(0, {8'h00, mem[7]});
    // Two sources pending with the gate closed, then opened
    sp_wr_en = 1'b1;
    sp_wr_data = 16'h0100;
    irq_req = 8'h06;
    ctrl.instr_done = 1'b1;
    ctrl.long_instr = 1'b1;
    fetch_word = r[15:0];
    step(1);
    sp_wr_en = 1'b0;
    ctrl.long_instr = 1'b0;
    ctrl.int_set_op = 1'b1;
    note(7, 16'h0100);
    note(16, r[15:0]);
    note(17, r[15:0]);
    note(18, 16'h0001);
    note(10, 16'h0000);
    step(1);
    ctrl.int_set_op = 1'b0;
    fl[7] = 1'b1;
    note(6, {8'h00, fl});
    step(1);
    note(10, 16'h0000);
    step(1);
    ctrl.instr_done = 1'b0;
    fl[7] = 1'b0;
    note(10, 16'h0001);
    note(11, 16'h0001);
    note(12, 16'h0002);
    note(6, {8'h00, fl});
    note(7, 16'h00FE);
    note(13, 16'h0001);
    note(15, 16'h0003);
    ctrl.irq_return_op = 1'b1;
    step(1);
    ctrl.irq_return_op = 1'b0;
    ctrl.call_op = 1'b1;
    fl[7] = 1'b1;
    note(6, {8'h00, fl});
    note(7, 16'h0100);
    step(1);
    ctrl.call_op = 1'b0;
    irq_req = 8'h00;
    note(7, 16'h00FE);
    note(13, 16'h0001);
    note(15, 16'h0002);
    step(2);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
